// ===== pkg/mbc_consts.vh
// constants for the multiplexed-bus processor pin interface
// assumes it is included by bare name from logic/ files
// Operation
// - the upper eight address bits leave on their own output bus, bit 15 on top.
// - the low address and the data share one two-way bus, address first, data after.
// - the address latch strobe is high through the first clock state of every cycle.
// - the system clock output has exactly twice the period of the input clock.
// - a hold request is answered with the grant acknowledge once it is accepted.
// - an accepted general request stops the program counter, is acknowledged, and an opcode is read.
// - the interrupt acknowledge goes low while the general request is being acknowledged.
// - read and write strobes are active low and float during hold, halt and reset.
// - reset clears the program counter, the interrupt enable flag and the grant flip-flop.
// - the reset indicator output shows that the processor is being reset.
// - three maskable restart inputs vector on their own, high over mid over low over general.
// - the trap input is a non-maskable restart above every other source.
// - two status bits and the memory/I-O select give each cycle's kind, stable at the strobe fall.
// - the read-mask instruction copies the serial input level into bit 7.
// - the serial output changes only on the set-mask instruction and holds otherwise.
`ifndef MBC_CONSTS_VH
`define MBC_CONSTS_VH

`define MBC_ST_IDLE 3'H0
`define MBC_ST_T1 3'H1
`define MBC_ST_T2 3'H2
`define MBC_ST_TW 3'H3
`define MBC_ST_T3 3'H4
`define MBC_ST_HOLD 3'H5

`define MBC_STAT_IDLE 2'H0
`define MBC_STAT_WRITE 2'H1
`define MBC_STAT_READ 2'H2
`define MBC_STAT_INTA 2'H3

`define MBC_VEC_TRAP 16'H0024
`define MBC_VEC_HIGH 16'H003C
`define MBC_VEC_MID 16'H0034
`define MBC_VEC_LOW 16'H002C
`define MBC_PC_RESET 16'H0000

`define MBC_SIM_MASK_HI 2
`define MBC_SIM_MASK_LO 0
`define MBC_SIM_MSE 3
`define MBC_SIM_R75 4
`define MBC_SIM_SDE 6
`define MBC_SIM_SOD 7

`define MBC_IN_HOLD 7
`define MBC_IN_READY 6
`define MBC_IN_GENERAL_INTERRUPT_REQUEST 5
`define MBC_IN_R75 4
`define MBC_IN_R65 3
`define MBC_IN_R55 2
`define MBC_IN_TRAP 1
`define MBC_IN_SID 0

`endif

// ===== logic/mbc_sync.v
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are independent levels; no bus coherence
`timescale 1ns/10ps
`default_nettype none
module mbc_sync #(
	parameter WIDTH = 8
) (
	input wire i_clock,
	input wire i_reset_n,
	input wire [WIDTH-1:0] i_async,
	output reg [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta;

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta <= {WIDTH{1'b0}};
			o_sync <= {WIDTH{1'b0}};
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== logic/mbc_top.v
// pin interface of an 8-bit processor: bus cycles, hold, interrupts, serial bit
// assumes the core side is on I_CLOCK and pulses its commands for one cycle
`timescale 1ns/10ps
`default_nettype none
`include "mbc_consts.vh"
module mbc_top (
	input wire I_CLOCK,
	input wire I_RESET_N,
	input wire I_HOLD_REQUEST,
	input wire I_READY,
	input wire I_GENERAL_INTERRUPT_REQUEST,
	input wire I_RESTART_IRQ_HIGH,
	input wire I_RESTART_IRQ_MID,
	input wire I_RESTART_IRQ_LOW,
	input wire I_TRAP,
	input wire I_SERIAL_BIT_IN,
	input wire [7:0] I_AD_IN,
	input wire I_CYC_REQ,
	input wire I_CYC_WRITE,
	input wire I_CYC_IO,
	input wire [15:0] I_CYC_ADDR,
	input wire [7:0] I_CYC_WDATA,
	input wire I_HALT,
	input wire I_PC_LOAD,
	input wire [15:0] I_PC_LOAD_VALUE,
	input wire I_PC_INCREMENT,
	input wire I_INSTR_BOUNDARY,
	input wire I_INT_ENABLE_SET,
	input wire I_INT_ENABLE_CLEAR,
	input wire I_SET_MASK_INSTRUCTION,
	input wire [7:0] I_SET_MASK_DATA,
	input wire I_READ_MASK_INSTRUCTION,
	output reg [7:0] O_AD_OUT,
	output reg O_AD_OE_N,
	output reg [7:0] O_ADDR_HIGH,
	output reg O_ADDR_OE_N,
	output reg O_ALE,
	output reg O_SYS_CLOCK,
	output reg O_BUS_GRANT_ACK,
	output reg O_INTERRUPT_ACK_N,
	output reg O_READ_STROBE_N,
	output reg O_WRITE_STROBE_N,
	output reg O_STROBE_OE_N,
	output reg O_CYCLE_STATUS_BIT0,
	output reg O_CYCLE_STATUS_BIT1,
	output reg O_IO_MEM_SELECT,
	output reg O_RESET_INDICATOR_OUT,
	output reg O_CYC_BUSY,
	output reg O_CYC_DONE,
	output reg [7:0] O_CYC_RDATA,
	output reg [15:0] O_PROGRAM_COUNTER,
	output reg O_INTERRUPT_ENABLE_FLAG,
	output reg O_IRQ_TAKEN,
	output reg O_IRQ_EXTERNAL,
	output reg [15:0] O_IRQ_VECTOR,
	output reg [7:0] O_IRQ_OPCODE,
	output reg [7:0] O_READ_MASK_DATA,
	output reg O_SERIAL_BIT_OUT
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	wire [7:0] ctl_s;
	wire [7:0] ad_s;

	mbc_sync #(.WIDTH(8)) u_ctl_sync (
		.i_clock(I_CLOCK),
		.i_reset_n(I_RESET_N),
		.i_async({I_HOLD_REQUEST, I_READY, I_GENERAL_INTERRUPT_REQUEST, I_RESTART_IRQ_HIGH,
			I_RESTART_IRQ_MID, I_RESTART_IRQ_LOW, I_TRAP, I_SERIAL_BIT_IN}),
		.o_sync(ctl_s)
	);

	mbc_sync #(.WIDTH(8)) u_ad_sync (
		.i_clock(I_CLOCK),
		.i_reset_n(I_RESET_N),
		.i_async(I_AD_IN),
		.o_sync(ad_s)
	);

	wire hold_s = ctl_s[`MBC_IN_HOLD];
	wire ready_s = ctl_s[`MBC_IN_READY];
	wire general_interrupt_request_s = ctl_s[`MBC_IN_GENERAL_INTERRUPT_REQUEST];
	wire r75_s = ctl_s[`MBC_IN_R75];
	wire r65_s = ctl_s[`MBC_IN_R65];
	wire r55_s = ctl_s[`MBC_IN_R55];
	wire trap_s = ctl_s[`MBC_IN_TRAP];
	wire sid_s = ctl_s[`MBC_IN_SID];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg [2:0] state;
	reg req_write;
	reg req_io;
	reg [15:0] req_addr;
	reg [7:0] req_wdata;
	reg act_write;
	reg act_inta;
	reg inta_pend;
	reg [2:0] masks;
	reg r75_latch;
	reg r75_prev;
	reg trap_latch;
	reg trap_prev;

	// one clock state spans two input clocks; advance on the high phase
	wire tick = O_SYS_CLOCK;
	wire [15:0] start_addr = inta_pend ? O_PROGRAM_COUNTER : req_addr;
	wire [1:0] start_status = inta_pend ? `MBC_STAT_INTA :
		(req_write ? `MBC_STAT_WRITE : `MBC_STAT_READ);

	always @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state <= `MBC_ST_IDLE;
			req_write <= 1'b0;
			req_io <= 1'b0;
			req_addr <= 16'H0000;
			req_wdata <= 8'H00;
			act_write <= 1'b0;
			act_inta <= 1'b0;
			inta_pend <= 1'b0;
			masks <= 3'H7;
			r75_latch <= 1'b0;
			r75_prev <= 1'b0;
			trap_latch <= 1'b0;
			trap_prev <= 1'b0;
			O_AD_OUT <= 8'H00;
			O_AD_OE_N <= 1'b1;
			O_ADDR_HIGH <= 8'H00;
			O_ADDR_OE_N <= 1'b1;
			O_ALE <= 1'b0;
			O_SYS_CLOCK <= 1'b0;
			O_BUS_GRANT_ACK <= 1'b0;
			O_INTERRUPT_ACK_N <= 1'b1;
			O_READ_STROBE_N <= 1'b1;
			O_WRITE_STROBE_N <= 1'b1;
			O_STROBE_OE_N <= 1'b1;
			O_CYCLE_STATUS_BIT0 <= 1'b0;
			O_CYCLE_STATUS_BIT1 <= 1'b0;
			O_IO_MEM_SELECT <= 1'b0;
			O_RESET_INDICATOR_OUT <= 1'b1;
			O_CYC_BUSY <= 1'b0;
			O_CYC_DONE <= 1'b0;
			O_CYC_RDATA <= 8'H00;
			O_PROGRAM_COUNTER <= `MBC_PC_RESET;
			O_INTERRUPT_ENABLE_FLAG <= 1'b0;
			O_IRQ_TAKEN <= 1'b0;
			O_IRQ_EXTERNAL <= 1'b0;
			O_IRQ_VECTOR <= 16'H0000;
			O_IRQ_OPCODE <= 8'H00;
			O_READ_MASK_DATA <= 8'H00;
			O_SERIAL_BIT_OUT <= 1'b0;
		end else begin
			O_SYS_CLOCK <= ~O_SYS_CLOCK;
			O_RESET_INDICATOR_OUT <= 1'b0;
			O_CYC_DONE <= 1'b0;
			O_IRQ_TAKEN <= 1'b0;

			// ------------------------------------------------------------
			// core cycle request and program counter
			// ------------------------------------------------------------
			if (I_CYC_REQ && !O_CYC_BUSY) begin
				O_CYC_BUSY <= 1'b1;
				req_write <= I_CYC_WRITE;
				req_io <= I_CYC_IO;
				req_addr <= I_CYC_ADDR;
				req_wdata <= I_CYC_WDATA;
			end
			if (I_PC_LOAD) begin
				O_PROGRAM_COUNTER <= I_PC_LOAD_VALUE;
			end else if (I_PC_INCREMENT && !inta_pend) begin
				O_PROGRAM_COUNTER <= O_PROGRAM_COUNTER + 16'H0001;
			end

			// ------------------------------------------------------------
			// mask, serial and interrupt logic
			// ------------------------------------------------------------
			r75_prev <= r75_s;
			trap_prev <= trap_s;
			if (I_SET_MASK_INSTRUCTION) begin
				if (I_SET_MASK_DATA[`MBC_SIM_MSE]) begin
					masks <= I_SET_MASK_DATA[`MBC_SIM_MASK_HI:`MBC_SIM_MASK_LO];
				end
				if (I_SET_MASK_DATA[`MBC_SIM_R75]) begin
					r75_latch <= 1'b0;
				end
				if (I_SET_MASK_DATA[`MBC_SIM_SDE]) begin
					O_SERIAL_BIT_OUT <= I_SET_MASK_DATA[`MBC_SIM_SOD];
				end
			end
			if (I_READ_MASK_INSTRUCTION) begin
				O_READ_MASK_DATA <= {sid_s, r75_latch, r65_s, r55_s, O_INTERRUPT_ENABLE_FLAG, masks};
			end
			if (I_INT_ENABLE_SET) begin
				O_INTERRUPT_ENABLE_FLAG <= 1'b1;
			end else if (I_INT_ENABLE_CLEAR) begin
				O_INTERRUPT_ENABLE_FLAG <= 1'b0;
			end
			if (I_INSTR_BOUNDARY && !inta_pend) begin
				// trap first, ignores enable and masks
				if (trap_latch) begin
					trap_latch <= 1'b0;
					O_INTERRUPT_ENABLE_FLAG <= 1'b0;
					O_IRQ_TAKEN <= 1'b1;
					O_IRQ_EXTERNAL <= 1'b0;
					O_IRQ_VECTOR <= `MBC_VEC_TRAP;
					O_PROGRAM_COUNTER <= `MBC_VEC_TRAP;
				end else if (O_INTERRUPT_ENABLE_FLAG && r75_latch && !masks[2]) begin
					r75_latch <= 1'b0;
					O_INTERRUPT_ENABLE_FLAG <= 1'b0;
					O_IRQ_TAKEN <= 1'b1;
					O_IRQ_EXTERNAL <= 1'b0;
					O_IRQ_VECTOR <= `MBC_VEC_HIGH;
					O_PROGRAM_COUNTER <= `MBC_VEC_HIGH;
				end else if (O_INTERRUPT_ENABLE_FLAG && r65_s && !masks[1]) begin
					O_INTERRUPT_ENABLE_FLAG <= 1'b0;
					O_IRQ_TAKEN <= 1'b1;
					O_IRQ_EXTERNAL <= 1'b0;
					O_IRQ_VECTOR <= `MBC_VEC_MID;
					O_PROGRAM_COUNTER <= `MBC_VEC_MID;
				end else if (O_INTERRUPT_ENABLE_FLAG && r55_s && !masks[0]) begin
					O_INTERRUPT_ENABLE_FLAG <= 1'b0;
					O_IRQ_TAKEN <= 1'b1;
					O_IRQ_EXTERNAL <= 1'b0;
					O_IRQ_VECTOR <= `MBC_VEC_LOW;
					O_PROGRAM_COUNTER <= `MBC_VEC_LOW;
				end else if (O_INTERRUPT_ENABLE_FLAG && general_interrupt_request_s) begin
					inta_pend <= 1'b1;
					O_INTERRUPT_ENABLE_FLAG <= 1'b0;
				end
			end
			// edges set after the clears so a same-cycle event is kept
			if (r75_s && !r75_prev) begin
				r75_latch <= 1'b1;
			end
			if (trap_s && !trap_prev) begin
				trap_latch <= 1'b1;
			end

			// ------------------------------------------------------------
			// bus cycle sequencer
			// ------------------------------------------------------------
			case (state)
			`MBC_ST_IDLE: begin
				if (tick) begin
					if (hold_s) begin
						state <= `MBC_ST_HOLD;
						O_BUS_GRANT_ACK <= 1'b1;
						O_AD_OE_N <= 1'b1;
						O_ADDR_OE_N <= 1'b1;
						O_STROBE_OE_N <= 1'b1;
						{O_CYCLE_STATUS_BIT1, O_CYCLE_STATUS_BIT0} <= `MBC_STAT_IDLE;
					end else if (inta_pend || O_CYC_BUSY) begin
						state <= `MBC_ST_T1;
						act_inta <= inta_pend;
						act_write <= !inta_pend && req_write;
						O_ALE <= 1'b1;
						O_ADDR_HIGH <= start_addr[15:8];
						O_ADDR_OE_N <= 1'b0;
						O_AD_OUT <= start_addr[7:0];
						O_AD_OE_N <= 1'b0;
						O_STROBE_OE_N <= 1'b0;
						// status stands before the strobe falls
						{O_CYCLE_STATUS_BIT1, O_CYCLE_STATUS_BIT0} <= start_status;
						O_IO_MEM_SELECT <= inta_pend || req_io;
					end else begin
						O_STROBE_OE_N <= I_HALT;
					end
				end
			end
			`MBC_ST_T1: begin
				if (tick) begin
					state <= `MBC_ST_T2;
					O_ALE <= 1'b0;
					if (act_write) begin
						O_AD_OUT <= req_wdata;
					end else begin
						O_AD_OE_N <= 1'b1;
					end
					// acknowledge low in place of read
					if (act_inta) begin
						O_INTERRUPT_ACK_N <= 1'b0;
					end else if (act_write) begin
						O_WRITE_STROBE_N <= 1'b0;
					end else begin
						O_READ_STROBE_N <= 1'b0;
					end
				end
			end
			`MBC_ST_T2, `MBC_ST_TW: begin
				if (tick) begin
					state <= ready_s ? `MBC_ST_T3 : `MBC_ST_TW;
				end
			end
			`MBC_ST_T3: begin
				if (tick) begin
					state <= `MBC_ST_IDLE;
					O_READ_STROBE_N <= 1'b1;
					O_WRITE_STROBE_N <= 1'b1;
					O_INTERRUPT_ACK_N <= 1'b1;
					O_AD_OE_N <= 1'b1;
					{O_CYCLE_STATUS_BIT1, O_CYCLE_STATUS_BIT0} <= `MBC_STAT_IDLE;
					if (act_inta) begin
						inta_pend <= 1'b0;
						O_IRQ_TAKEN <= 1'b1;
						O_IRQ_EXTERNAL <= 1'b1;
						O_IRQ_OPCODE <= ad_s;
					end else begin
						O_CYC_DONE <= 1'b1;
						O_CYC_RDATA <= ad_s;
						O_CYC_BUSY <= 1'b0;
					end
				end
			end
			`MBC_ST_HOLD: begin
				if (tick && !hold_s) begin
					state <= `MBC_ST_IDLE;
					O_BUS_GRANT_ACK <= 1'b0;
					O_STROBE_OE_N <= I_HALT;
				end
			end
			default: begin
				state <= `MBC_ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== dv/mbc_top_checker.sv
// assertions on the pins of the processor pin interface
// assumes binding to mbc_top; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module mbc_top_checker (
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic I_SET_MASK_INSTRUCTION,
	input wire logic [7:0] I_SET_MASK_DATA,
	input wire logic O_AD_OE_N,
	input wire logic [7:0] O_ADDR_HIGH,
	input wire logic O_ADDR_OE_N,
	input wire logic O_ALE,
	input wire logic O_SYS_CLOCK,
	input wire logic O_BUS_GRANT_ACK,
	input wire logic O_INTERRUPT_ACK_N,
	input wire logic O_READ_STROBE_N,
	input wire logic O_WRITE_STROBE_N,
	input wire logic O_STROBE_OE_N,
	input wire logic O_CYCLE_STATUS_BIT0,
	input wire logic O_CYCLE_STATUS_BIT1,
	input wire logic O_IO_MEM_SELECT,
	input wire logic O_RESET_INDICATOR_OUT,
	input wire logic O_SERIAL_BIT_OUT
);
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RESET_N);
	// ----
	// pin relations
	// ----
	chk_sysclk_half: assert property (
		$past(I_RESET_N) |-> O_SYS_CLOCK != $past(O_SYS_CLOCK))
		else $error("system clock did not toggle");
	chk_ale_first: assert property ($rose(O_ALE) |=> O_ALE ##1 !O_ALE)
		else $error("address strobe not two clocks wide");
	chk_ale_drive: assert property (O_ALE |-> !O_AD_OE_N && !O_ADDR_OE_N)
		else $error("address not driven with strobe");
	chk_read_status: assert property ($fell(O_READ_STROBE_N) |->
		$fell(O_ALE) && {O_CYCLE_STATUS_BIT1, O_CYCLE_STATUS_BIT0} == 2'H2)
		else $error("read strobe without read status");
	chk_write_status: assert property ($fell(O_WRITE_STROBE_N) |->
		{O_CYCLE_STATUS_BIT1, O_CYCLE_STATUS_BIT0} == 2'H1 && !O_AD_OE_N)
		else $error("write strobe without write status");
	chk_addr_steady: assert property (!O_READ_STROBE_N || !O_WRITE_STROBE_N |->
		$stable(O_ADDR_HIGH))
		else $error("address moved under strobe");
	chk_strobe_excl: assert property (O_READ_STROBE_N || O_WRITE_STROBE_N)
		else $error("both strobes low");
	chk_hold_float: assert property (O_BUS_GRANT_ACK |->
		O_STROBE_OE_N && O_AD_OE_N && O_ADDR_OE_N)
		else $error("bus driven during hold");
	chk_ack_status: assert property (!O_INTERRUPT_ACK_N |->
		{O_CYCLE_STATUS_BIT1, O_CYCLE_STATUS_BIT0} == 2'H3 && O_IO_MEM_SELECT)
		else $error("acknowledge without ack status");
	chk_sod_hold: assert property (!I_SET_MASK_INSTRUCTION |=> $stable(O_SERIAL_BIT_OUT))
		else $error("serial output moved");
	chk_sod_set: assert property (I_SET_MASK_INSTRUCTION && I_SET_MASK_DATA[6] |=>
		O_SERIAL_BIT_OUT == $past(I_SET_MASK_DATA[7]))
		else $error("serial output not set");
	chk_ind_low: assert property ($past(I_RESET_N) |-> !O_RESET_INDICATOR_OUT)
		else $error("reset indicator high after reset");
endmodule
bind mbc_top mbc_top_checker chk_i (.*);
`default_nettype wire

// ===== dv/mbc_mem_model.sv
// memory and I/O device on the far side of the multiplexed bus
// assumes the bench resolves the AD wire and feeds it back here
`timescale 1ns/10ps
`default_nettype none
module mbc_mem_model (
	input wire logic i_clock,
	input wire logic i_ale,
	input wire logic [7:0] i_ad,
	input wire logic [7:0] i_addr_high,
	input wire logic i_read_strobe_n,
	input wire logic i_write_strobe_n,
	input wire logic i_interrupt_ack_n,
	input wire logic [3:0] i_waits,
	input wire logic [7:0] i_opcode,
	output logic [7:0] o_ad,
	output logic o_ready,
	output logic [15:0] o_addr = 16'H0000,
	output logic [7:0] o_wdata = 8'H00
);
	logic [3:0] cnt = 4'H0;
	logic patt = 1'B0;
	wire logic act = !i_read_strobe_n || !i_interrupt_ack_n;
	wire logic sel = act || !i_write_strobe_n;
	always @(posedge i_clock) begin
		patt <= !patt;
		if (i_ale)
			o_addr <= {i_addr_high, i_ad};
		if (!i_write_strobe_n)
			o_wdata <= i_ad;
		cnt <= sel ? cnt + 4'H1 : 4'H0;
	end
	assign o_ready = sel && (cnt >= i_waits);
	assign o_ad = !act ? {8{patt}} :
		(!i_interrupt_ack_n ? i_opcode : o_addr[7:0] ^ o_addr[15:8]);
endmodule
`default_nettype wire

// ===== dv/mbc_top_tb_top.sv
// bench for the processor pin interface
// assumes the memory model and checker in this folder
`timescale 1ns/10ps
`default_nettype none
`include "mbc_consts.vh"
module mbc_top_tb_top;
	logic clk, rst_n, hold, general_interrupt_request, r_hi, r_mid, r_lo, trap, serial_bit_in;
	logic req, wr, io, bnd, ie_set, sim, read_mask_instruction, halt;
	logic [15:0] addr;
	logic [7:0] wd, simd;
	logic [3:0] waits;
	wire logic [7:0] ad_o, ad_p, ad, ahi, rdata, iop, rimd, wdat;
	wire logic [15:0] pc, vec, maddr;
	wire logic ad_oe_n, ale, grant, inta_n, rd_n, wr_n, soe_n, rind, done, ien, taken, ext;
	wire logic serial_bit_out, rdy, busy;
	int num_errors = 0;
	int checks_done = 0;
	assign ad = ad_oe_n ? ad_p : ad_o;
	mbc_top dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_HOLD_REQUEST(hold), .I_READY(rdy),
		.I_GENERAL_INTERRUPT_REQUEST(general_interrupt_request), .I_RESTART_IRQ_HIGH(r_hi),
		.I_RESTART_IRQ_MID(r_mid), .I_RESTART_IRQ_LOW(r_lo), .I_TRAP(trap),
		.I_SERIAL_BIT_IN(serial_bit_in), .I_AD_IN(ad), .I_CYC_REQ(req), .I_CYC_WRITE(wr),
		.I_CYC_IO(io), .I_CYC_ADDR(addr), .I_CYC_WDATA(wd), .I_HALT(halt),
		.I_PC_LOAD(1'B0), .I_PC_LOAD_VALUE(16'H0000), .I_PC_INCREMENT(1'B0),
		.I_INSTR_BOUNDARY(bnd), .I_INT_ENABLE_SET(ie_set), .I_INT_ENABLE_CLEAR(1'B0),
		.I_SET_MASK_INSTRUCTION(sim), .I_SET_MASK_DATA(simd), .I_READ_MASK_INSTRUCTION(read_mask_instruction),
		.O_AD_OUT(ad_o), .O_AD_OE_N(ad_oe_n), .O_ADDR_HIGH(ahi), .O_ADDR_OE_N(),
		.O_ALE(ale), .O_SYS_CLOCK(), .O_BUS_GRANT_ACK(grant), .O_INTERRUPT_ACK_N(inta_n),
		.O_READ_STROBE_N(rd_n), .O_WRITE_STROBE_N(wr_n), .O_STROBE_OE_N(soe_n),
		.O_CYCLE_STATUS_BIT0(), .O_CYCLE_STATUS_BIT1(), .O_IO_MEM_SELECT(),
		.O_RESET_INDICATOR_OUT(rind), .O_CYC_BUSY(busy), .O_CYC_DONE(done),
		.O_CYC_RDATA(rdata), .O_PROGRAM_COUNTER(pc), .O_INTERRUPT_ENABLE_FLAG(ien),
		.O_IRQ_TAKEN(taken), .O_IRQ_EXTERNAL(ext), .O_IRQ_VECTOR(vec),
		.O_IRQ_OPCODE(iop), .O_READ_MASK_DATA(rimd), .O_SERIAL_BIT_OUT(serial_bit_out));
	mbc_mem_model mem (.i_clock(clk), .i_ale(ale), .i_ad(ad), .i_addr_high(ahi),
		.i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_interrupt_ack_n(inta_n),
		.i_waits(waits), .i_opcode(8'HEF), .o_ad(ad_p), .o_ready(rdy),
		.o_addr(maddr), .o_wdata(wdat));
	// ----
	// helpers
	// ----
	task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic late(input string n);
		num_errors++;
		$display("CHECK FAILED %s expected 1 seen 0", n);
		results();
	endtask
	task automatic cyc(input logic w, input logic i, input logic [15:0] a,
		input logic [7:0] d, input logic [3:0] ws);
		int k;
		waits = ws;
		{req, wr, io, addr, wd} = {1'B1, w, i, a, d};
		tick(1);
		req = 0;
		chk("cycle busy", busy, 16'H1);
		for (k = 0; k < 60 && done !== 1'B1; k++)
			tick(1);
		if (k == 60)
			late("cycle done");
		chk("cycle idle", busy, 16'H0);
	endtask
	task automatic sm(input logic [7:0] d);
		simd = d;
		sim = 1;
		tick(1);
		sim = 0;
		tick(1);
	endtask
	task automatic take(input logic [15:0] v, input logic x);
		int k;
		ie_set = 1;
		tick(1);
		{ie_set, bnd} = 2'H1;
		tick(1);
		bnd = 0;
		for (k = 0; k < 40 && taken !== 1'B1; k++)
			tick(1);
		if (k == 40)
			late("irq taken");
		chk("irq kind", ext, x);
		chk("irq target", x ? iop : vec, v);
		tick(1);
		chk("int enable", ien, 16'H0);
	endtask
	task automatic rd_mask(input logic s);
		serial_bit_in = s;
		tick(3);
		read_mask_instruction = 1;
		tick(1);
		read_mask_instruction = 0;
		chk("read mask", rimd[7], s);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_bus;
		int k;
		cyc(0, 0, 16'HA5C3, 8'H00, 3);
		chk("read data", rdata, 16'H66);
		chk("address", maddr, 16'HA5C3);
		cyc(1, 1, 16'H12FE, 8'H3C, 0);
		chk("write data", wdat, 16'H3C);
		chk("strobes", {rd_n, wr_n}, 16'H3);
		hold = 1;
		for (k = 0; k < 40 && grant !== 1'B1; k++)
			tick(1);
		if (k == 40)
			late("grant");
		chk("hold float", {soe_n, ad_oe_n}, 16'H3);
		hold = 0;
		tick(6);
		chk("grant off", grant, 16'H0);
		halt = 1;
		tick(3);
		chk("halt float", soe_n, 16'H1);
		halt = 0;
		tick(3);
		chk("strobe drive", soe_n, 16'H0);
	endtask
	task automatic t_irq;
		sm(8'H08);
		{trap, r_hi, r_mid, r_lo, general_interrupt_request} = 5'H1F;
		tick(3);
		take(`MBC_VEC_TRAP, 0);
		take(`MBC_VEC_HIGH, 0);
		chk("pc vector", pc, `MBC_VEC_HIGH);
		take(`MBC_VEC_MID, 0);
		r_mid = 0;
		tick(3);
		take(`MBC_VEC_LOW, 0);
		r_lo = 0;
		tick(3);
		take(16'H00EF, 1);
		{trap, r_hi, general_interrupt_request} = 3'H0;
	endtask
	task automatic t_serial;
		sm(8'HC0);
		chk("serial out", serial_bit_out, 16'H1);
		sm(8'H00);
		tick(2);
		chk("serial kept", serial_bit_out, 16'H1);
		sm(8'H40);
		chk("serial out", serial_bit_out, 16'H0);
		rd_mask(1);
		rd_mask(0);
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_n, hold, general_interrupt_request, r_hi, r_mid, r_lo, trap, serial_bit_in, req, wr, io, halt} = 12'H000;
		{bnd, ie_set, sim, read_mask_instruction, addr, wd, simd, waits} = 40'H0;
		tick(4);
		chk("reset out", rind, 16'H1);
		chk("pc reset", pc, `MBC_PC_RESET);
		chk("int enable", ien, 16'H0);
		chk("grant", grant, 16'H0);
		chk("strobe float", soe_n, 16'H1);
		tick(1);
		rst_n = 1;
		tick(1);
		chk("reset out", rind, 16'H0);
		t_bus();
		t_irq();
		t_serial();
		results();
	end
endmodule
`default_nettype wire
